// ===== hbridge_consts.svh
`ifndef HBRIDGE_CONSTS_SVH
`define HBRIDGE_CONSTS_SVH

// Register byte addresses
`define REG_CTRL_ADDR 8'h00
`define REG_OSC_ADDR 8'h04
`define REG_STATUS_ADDR 8'h08

// Control register fields
`define CTRL_CHOP_EN_BIT 0
`define CTRL_OC_SEL_LSB 1
`define CTRL_OC_SEL_MSB 2
`define CTRL_MASK 32'h0000_0007
`define CTRL_RESET 32'h0000_0001

// Oscillator period register, in system clock cycles
`define OSC_MASK 32'h0000_FFFF
`define OSC_RESET 32'h0000_00C8

// Status register fields
`define ST_THERMAL_BIT 0
`define ST_OVERCURRENT_BIT 1
`define ST_SENSE_OV_BIT 2
`define ST_UNDERVOLTAGE_BIT 3
`define ST_OVERVOLTAGE_BIT 4
`define ST_DISCHARGE_BIT 5
`define ST_CHOP_LSB 6
`define ST_LEG_LSB 8

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing
`define CLK_MHZ 20
`define OC_TIME_SHORT_NS 1600
`define OC_TIME_MID_NS 2800
`define OC_TIME_LONG_NS 12400
`define DEAD_TIME_NS 200
`define NS_TO_CYCLES(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define DISCH_TICKS 4

`endif

// ===== hbridge_pkg.sv
package hbridge_pkg;

	typedef enum logic [1:0] {
		CHOP_CHARGE = 2'b00,
		CHOP_DISCH_FIRST = 2'b01,
		CHOP_DISCH_SECOND = 2'b10,
		CHOP_CHARGE_HOLD = 2'b11
	} chop_state_t;

	// Bit 1 drives the upper transistor, bit 0 the lower one
	typedef enum logic [1:0] {
		LEG_OFF = 2'b00,
		LEG_LOW = 2'b01,
		LEG_HIGH = 2'b10
	} leg_t;

endpackage

// ===== hbridge_mode_fault_chopper.sv
// Function
// - Direction pair selects one direction, the other, or short brake when both high.
// - Selected direction with modulation low gives short brake on both outputs.
// - Both direction inputs low turns both outputs off, whatever modulation does.
// - Latched shutdowns persist until host drives both direction inputs low or undervoltage is seen.
// - Fault flag pulled low in normal operation, released during any shutdown.
// - Undervoltage turns all outputs off; recovers by itself when indication drops.
// - Overvoltage turns all outputs off; recovers by itself when indication drops.
// - Over-temperature turns outputs off until released by both direction inputs low or by undervoltage.
// - Any transistor overcurrent beyond detection time turns outputs off and latches.
// - Overcurrent detection time selectable among three settings.
// - Dead time inserted whenever a leg's upper and lower transistor swap.
// - Sense overvoltage turns outputs off, releases flag, latches like overcurrent.
// - Chopping enters discharge, meaning short brake, when sense reaches threshold.
// - Discharge lasts four oscillator cycles, then charge follows.
// - Threshold still high on charge gives four more discharge cycles, then holds charge.
// - Discharge once begun runs its full four cycles regardless of current.
// - Short brake wins when chopping and modulation disagree.
// - Chopping oscillator period is programmable and clocks the discharge counter.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`include "hbridge_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hbridge_mode_fault_chopper
	import hbridge_pkg::*;
#(
	parameter int OC_CNT_W = 8,
	parameter int DEAD_CNT_W = 4,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	// Host control inputs
	input wire logic I_DIRECTION_IN_A,
	input wire logic I_DIRECTION_IN_B,
	input wire logic I_SPEED_PWM,
	// Comparator indications
	input wire logic I_UNDERVOLTAGE_LOCKOUT,
	input wire logic I_OVERVOLTAGE_SHUTDOWN,
	input wire logic I_THERMAL_SHUTDOWN,
	input wire logic [3:0] I_OVERCURRENT_SHUTDOWN,
	input wire logic I_SENSE_OVERVOLTAGE,
	input wire logic I_SENSE_AT_THRESHOLD,
	// Bridge gate drives
	output logic O_BRIDGE_OUT_A_HI,
	output logic O_BRIDGE_OUT_A_LO,
	output logic O_BRIDGE_OUT_B_HI,
	output logic O_BRIDGE_OUT_B_LO,
	// Open-drain fault flag
	output logic O_FAULT_FLAG_O,
	output logic O_FAULT_FLAG_OE,
	// AXI4-Lite write channels
	input wire logic I_S_AXI_AWVALID,
	output logic O_S_AXI_AWREADY,
	input wire logic [ADDR_W-1:0] I_S_AXI_AWADDR,
	input wire logic I_S_AXI_WVALID,
	output logic O_S_AXI_WREADY,
	input wire logic [31:0] I_S_AXI_WDATA,
	input wire logic [3:0] I_S_AXI_WSTRB,
	output logic O_S_AXI_BVALID,
	input wire logic I_S_AXI_BREADY,
	output logic [1:0] O_S_AXI_BRESP,
	// AXI4-Lite read channels
	input wire logic I_S_AXI_ARVALID,
	output logic O_S_AXI_ARREADY,
	input wire logic [ADDR_W-1:0] I_S_AXI_ARADDR,
	output logic O_S_AXI_RVALID,
	input wire logic I_S_AXI_RREADY,
	output logic [31:0] O_S_AXI_RDATA,
	output logic [1:0] O_S_AXI_RRESP
);

	localparam int SYNC_W = 11;
	localparam logic [OC_CNT_W-1:0] OC_LIM_SHORT =
		OC_CNT_W'(`NS_TO_CYCLES(`OC_TIME_SHORT_NS));
	localparam logic [OC_CNT_W-1:0] OC_LIM_MID = OC_CNT_W'(`NS_TO_CYCLES(`OC_TIME_MID_NS));
	localparam logic [OC_CNT_W-1:0] OC_LIM_LONG =
		OC_CNT_W'(`NS_TO_CYCLES(`OC_TIME_LONG_NS));
	localparam logic [DEAD_CNT_W-1:0] DEAD_CYCLES =
		DEAD_CNT_W'(`NS_TO_CYCLES(`DEAD_TIME_NS));
	localparam logic [2:0] DISCH_LAST = 3'(`DISCH_TICKS - 1);

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RESET);

	// Input synchroniser; stage one feeds only stage two
	logic [SYNC_W-1:0] sync_1;
	logic [SYNC_W-1:0] sync_2;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			sync_1 <= '0;
			sync_2 <= '0;
		end else begin
			sync_1 <= {I_DIRECTION_IN_A, I_DIRECTION_IN_B, I_SPEED_PWM,
				I_UNDERVOLTAGE_LOCKOUT, I_OVERVOLTAGE_SHUTDOWN, I_THERMAL_SHUTDOWN,
				I_SENSE_OVERVOLTAGE, I_SENSE_AT_THRESHOLD, I_OVERCURRENT_SHUTDOWN[3:1]};
			sync_2 <= sync_1;
		end
	end
	logic oc_1_0;
	logic oc_2_0;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			oc_1_0 <= 1'b0;
			oc_2_0 <= 1'b0;
		end else begin
			oc_1_0 <= I_OVERCURRENT_SHUTDOWN[0];
			oc_2_0 <= oc_1_0;
		end
	end

	logic dir_a;
	logic dir_b;
	logic pwm_in;
	logic uv;
	logic ov;
	logic thermal;
	logic sense_ov;
	logic at_thr;
	logic [3:0] oc_in;
	assign {dir_a, dir_b, pwm_in, uv, ov, thermal, sense_ov, at_thr} = sync_2[10:3];
	assign oc_in = {sync_2[2:0], oc_2_0};
	logic release_req;
	assign release_req = !dir_a && !dir_b;

	// Registers
	logic [31:0] ctrl;
	logic [31:0] osc_period;
	logic chop_en;
	logic [1:0] oc_sel;
	assign chop_en = ctrl[`CTRL_CHOP_EN_BIT];
	assign oc_sel = ctrl[`CTRL_OC_SEL_MSB:`CTRL_OC_SEL_LSB];

	// Chopping oscillator
	logic [15:0] osc_cnt;
	logic osc_tick;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			osc_cnt <= '0;
			osc_tick <= 1'b0;
		end else if (osc_cnt + 16'h0001 >= osc_period[15:0]) begin
			osc_cnt <= '0;
			osc_tick <= 1'b1;
		end else begin
			osc_cnt <= osc_cnt + 16'h0001;
			osc_tick <= 1'b0;
		end
	end

	// Overcurrent detection timers, one per transistor
	logic [OC_CNT_W-1:0] oc_limit;
	always_comb begin
		case (oc_sel)
			2'b00: oc_limit = OC_LIM_SHORT;
			2'b01: oc_limit = OC_LIM_MID;
			default: oc_limit = OC_LIM_LONG;
		endcase
	end
	logic [3:0] oc_trip;
	logic [OC_CNT_W-1:0] oc_cnt [4];
	genvar t;
	generate
		for (t = 0; t < 4; t++) begin : g_oc
			always_ff @(posedge I_CLK_SYS) begin
				if (I_RESET || !oc_in[t]) begin
					oc_cnt[t] <= '0;
				end else if (oc_cnt[t] < oc_limit) begin
					oc_cnt[t] <= oc_cnt[t] + OC_CNT_W'(1);
				end
			end
			assign oc_trip[t] = oc_in[t] && (oc_cnt[t] >= oc_limit);
		end
	endgenerate

	// Fault latches; a set wins over the release
	logic thermal_lat;
	logic oc_lat;
	logic sense_lat;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET || uv) begin
			thermal_lat <= 1'b0;
			oc_lat <= 1'b0;
			sense_lat <= 1'b0;
		end else begin
			if (thermal) begin
				thermal_lat <= 1'b1;
			end else if (release_req) begin
				thermal_lat <= 1'b0;
			end
			if (|oc_trip) begin
				oc_lat <= 1'b1;
			end else if (release_req) begin
				oc_lat <= 1'b0;
			end
			if (sense_ov) begin
				sense_lat <= 1'b1;
			end else if (release_req) begin
				sense_lat <= 1'b0;
			end
		end
	end
	logic any_lat;
	logic run_ok;
	assign any_lat = thermal_lat || oc_lat || sense_lat;
	assign run_ok = !uv && !ov && !any_lat;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			O_FAULT_FLAG_O <= 1'b0;
			O_FAULT_FLAG_OE <= 1'b0;
		end else begin
			O_FAULT_FLAG_O <= 1'b0;
			O_FAULT_FLAG_OE <= run_ok;
		end
	end

	// Constant-current chopper
	chop_state_t chop_state;
	logic [2:0] disch_cnt;
	logic driving;
	logic discharge;
	assign driving = dir_a ^ dir_b;
	assign discharge = (chop_state == CHOP_DISCH_FIRST) || (chop_state == CHOP_DISCH_SECOND);
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET || uv || !run_ok || !chop_en || !driving) begin
			chop_state <= CHOP_CHARGE;
			disch_cnt <= '0;
		end else begin
			case (chop_state)
				CHOP_CHARGE: begin
					if (at_thr) begin
						chop_state <= CHOP_DISCH_FIRST;
						disch_cnt <= '0;
					end
				end
				CHOP_DISCH_FIRST: begin
					if (osc_tick) begin
						disch_cnt <= disch_cnt + 3'h1;
						if (disch_cnt == DISCH_LAST) begin
							disch_cnt <= '0;
							chop_state <= at_thr ? CHOP_DISCH_SECOND : CHOP_CHARGE;
						end
					end
				end
				CHOP_DISCH_SECOND: begin
					if (osc_tick) begin
						disch_cnt <= disch_cnt + 3'h1;
						if (disch_cnt == DISCH_LAST) begin
							disch_cnt <= '0;
							chop_state <= CHOP_CHARGE_HOLD;
						end
					end
				end
				CHOP_CHARGE_HOLD: begin
					if (!at_thr) begin
						chop_state <= CHOP_CHARGE;
					end
				end
				default: begin
					chop_state <= CHOP_CHARGE;
				end
			endcase
		end
	end

	// Mode decode into per-leg targets
	leg_t target [2];
	always_comb begin
		target[0] = LEG_OFF;
		target[1] = LEG_OFF;
		if (run_ok && !release_req) begin
			if (!dir_a && dir_b && pwm_in && !discharge) begin
				target[0] = LEG_LOW;
				target[1] = LEG_HIGH;
			end else if (dir_a && !dir_b && pwm_in && !discharge) begin
				target[0] = LEG_HIGH;
				target[1] = LEG_LOW;
			end else begin
				target[0] = LEG_LOW;
				target[1] = LEG_LOW;
			end
		end
	end

	// Bridge legs; every turn-off reloads the dead time, so a brief stop cannot shorten it
	leg_t leg [2];
	logic [DEAD_CNT_W-1:0] dead_cnt [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_leg
			always_ff @(posedge I_CLK_SYS) begin
				if (I_RESET) begin
					leg[g] <= LEG_OFF;
					dead_cnt[g] <= '0;
				end else if (leg[g] != LEG_OFF && target[g] != leg[g]) begin
					leg[g] <= LEG_OFF;
					dead_cnt[g] <= DEAD_CYCLES;
				end else if (dead_cnt[g] != '0) begin
					dead_cnt[g] <= dead_cnt[g] - DEAD_CNT_W'(1);
				end else begin
					leg[g] <= target[g];
				end
			end
		end
	endgenerate
	assign O_BRIDGE_OUT_A_HI = leg[0][1];
	assign O_BRIDGE_OUT_A_LO = leg[0][0];
	assign O_BRIDGE_OUT_B_HI = leg[1][1];
	assign O_BRIDGE_OUT_B_LO = leg[1][0];

	// AXI4-Lite slave; one write and one read at a time
	logic aw_have;
	logic w_have;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic next_aw_have;
	logic next_w_have;
	logic next_bvalid;
	logic next_rvalid;
	assign do_write = aw_have && w_have && !O_S_AXI_BVALID;
	always_comb begin
		next_aw_have = (aw_have || (I_S_AXI_AWVALID && O_S_AXI_AWREADY)) && !do_write;
		next_w_have = (w_have || (I_S_AXI_WVALID && O_S_AXI_WREADY)) && !do_write;
		next_bvalid = do_write || (O_S_AXI_BVALID && !I_S_AXI_BREADY);
		next_rvalid = (I_S_AXI_ARVALID && O_S_AXI_ARREADY) || (O_S_AXI_RVALID && !I_S_AXI_RREADY);
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			O_S_AXI_AWREADY <= 1'b0;
			O_S_AXI_WREADY <= 1'b0;
			O_S_AXI_BVALID <= 1'b0;
			O_S_AXI_BRESP <= `RESP_OKAY;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
				aw_addr <= I_S_AXI_AWADDR;
			end
			if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
				w_data <= I_S_AXI_WDATA;
				w_strb <= I_S_AXI_WSTRB;
			end
			O_S_AXI_AWREADY <= !next_aw_have && !next_bvalid;
			O_S_AXI_WREADY <= !next_w_have && !next_bvalid;
			O_S_AXI_BVALID <= next_bvalid;
			if (do_write) begin
				O_S_AXI_BRESP <= (aw_addr == `REG_CTRL_ADDR || aw_addr == `REG_OSC_ADDR ||
					aw_addr == `REG_STATUS_ADDR) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// Writable registers, per byte lane; status writes are ignored
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			ctrl <= `CTRL_RESET;
			osc_period <= `OSC_RESET;
		end else if (do_write) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b] && aw_addr == `REG_CTRL_ADDR) begin
					ctrl[b*8 +: 8] <= w_data[b*8 +: 8] & 8'(`CTRL_MASK >> (b*8));
				end
				if (w_strb[b] && aw_addr == `REG_OSC_ADDR) begin
					osc_period[b*8 +: 8] <= w_data[b*8 +: 8] & 8'(`OSC_MASK >> (b*8));
				end
			end
		end
	end

	logic [31:0] status;
	always_comb begin
		status = '0;
		status[`ST_THERMAL_BIT] = thermal_lat;
		status[`ST_OVERCURRENT_BIT] = oc_lat;
		status[`ST_SENSE_OV_BIT] = sense_lat;
		status[`ST_UNDERVOLTAGE_BIT] = uv;
		status[`ST_OVERVOLTAGE_BIT] = ov;
		status[`ST_DISCHARGE_BIT] = discharge;
		status[`ST_CHOP_LSB +: 2] = chop_state;
		status[`ST_LEG_LSB +: 4] = {leg[1], leg[0]};
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			O_S_AXI_ARREADY <= 1'b0;
			O_S_AXI_RVALID <= 1'b0;
			O_S_AXI_RDATA <= '0;
			O_S_AXI_RRESP <= `RESP_OKAY;
		end else begin
			O_S_AXI_ARREADY <= !next_rvalid;
			O_S_AXI_RVALID <= next_rvalid;
			if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
				O_S_AXI_RRESP <= `RESP_OKAY;
				case (I_S_AXI_ARADDR)
					`REG_CTRL_ADDR: O_S_AXI_RDATA <= ctrl;
					`REG_OSC_ADDR: O_S_AXI_RDATA <= osc_period;
					`REG_STATUS_ADDR: O_S_AXI_RDATA <= status;
					default: begin
						O_S_AXI_RDATA <= '0;
						O_S_AXI_RRESP <= `RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Checks
	property p_no_shoot_through;
		!(leg[0] == 2'b11) && !(leg[1] == 2'b11) &&
		!($past(leg[0]) == LEG_HIGH && leg[0] == LEG_LOW) &&
		!($past(leg[0]) == LEG_LOW && leg[0] == LEG_HIGH) &&
		!($past(leg[1]) == LEG_HIGH && leg[1] == LEG_LOW) &&
		!($past(leg[1]) == LEG_LOW && leg[1] == LEG_HIGH);
	endproperty
	a_no_shoot_through: assert property (p_no_shoot_through)
		else $error("leg swapped without dead time");

	property p_stop_off;
		(release_req && !$past(I_RESET)) |=> (leg[0] == LEG_OFF && leg[1] == LEG_OFF);
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("stop did not turn outputs off");

	property p_uv_clears;
		uv |=> (!thermal_lat && !oc_lat && !sense_lat && chop_state == CHOP_CHARGE &&
			leg[0] == LEG_OFF && leg[1] == LEG_OFF);
	endproperty
	a_uv_clears: assert property (p_uv_clears)
		else $error("undervoltage left state set");

	property p_ov_off;
		ov |=> (leg[0] == LEG_OFF && leg[1] == LEG_OFF);
	endproperty
	a_ov_off: assert property (p_ov_off)
		else $error("overvoltage left outputs on");

	property p_latch_holds;
		(thermal_lat && !release_req && !uv) |=> thermal_lat;
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("thermal latch lost early");

	property p_oc_latch;
		(!uv && |oc_trip) |=> (oc_lat ##1 (leg[0] == LEG_OFF && leg[1] == LEG_OFF));
	endproperty
	a_oc_latch: assert property (p_oc_latch)
		else $error("overcurrent not latched");

	property p_flag;
		!$past(I_RESET) |-> (!O_FAULT_FLAG_O && O_FAULT_FLAG_OE == !$past(uv || ov || any_lat));
	endproperty
	a_flag: assert property (p_flag)
		else $error("fault flag wrong");

	property p_brake_on_low_pwm;
		(run_ok && driving && !pwm_in) |-> (target[0] == LEG_LOW && target[1] == LEG_LOW);
	endproperty
	a_brake_on_low_pwm: assert property (p_brake_on_low_pwm)
		else $error("modulation low not brake");

	property p_disch_brake;
		(run_ok && discharge && !release_req) |-> (target[0] == LEG_LOW && target[1] == LEG_LOW);
	endproperty
	a_disch_brake: assert property (p_disch_brake)
		else $error("discharge not brake");

	property p_disch_full;
		(chop_state == CHOP_DISCH_FIRST && run_ok && chop_en && driving && !uv &&
			!(osc_tick && disch_cnt == DISCH_LAST)) |=>
			(chop_state == CHOP_DISCH_FIRST || !$past(run_ok && chop_en && driving) ||
			!run_ok);
	endproperty
	a_disch_full: assert property (p_disch_full)
		else $error("discharge cut short");

endmodule

`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
	// Clock
	input wire logic i_clk,
	// Requests from the bench
	input wire logic [1:0] i_mode,
	input wire logic i_pwm,
	input wire logic i_pwm_on_dir,
	// Pins toward the driver
	output logic o_dir_a,
	output logic o_dir_b,
	output logic o_pwm
);
	initial begin
		o_dir_a = 1'b0;
		o_dir_b = 1'b0;
		o_pwm = 1'b0;
	end

	// Mode changes pass straight through, no off gap inserted; with i_pwm_on_dir and i_pwm low a nonzero mode drives both directions high
	always @(posedge i_clk) begin
		if (i_pwm_on_dir && !i_pwm && i_mode != 2'h0) begin
			o_dir_a <= 1'b1;
			o_dir_b <= 1'b1;
			o_pwm <= 1'b1;
		end else begin
			o_dir_a <= i_mode[1];
			o_dir_b <= i_mode[0];
			o_pwm <= i_pwm_on_dir | i_pwm;
		end
	end
endmodule

`default_nettype wire

// ===== tb_top.sv
`include "hbridge_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk, reset, pwm, pwm_on_dir, dir_a, dir_b, spd;
	logic [1:0] mode;
	logic uv, ov, therm, sense_ov, thr;
	logic [3:0] oc;
	logic a_hi, a_lo, b_hi, b_lo, flag_o, flag_oe;
	logic aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
	logic ar_valid, ar_ready, r_valid, r_ready;
	logic [7:0] aw_addr, ar_addr;
	logic [31:0] w_data, r_data, rd;
	logic [3:0] w_strb;
	logic [1:0] b_resp, r_resp, resp;
	logic [3:0] legs;
	int n_errors, cmp_count, cycles, i, k;

	assign legs = {a_hi, a_lo, b_hi, b_lo};

	host_model host (.i_clk(clk), .i_mode(mode), .i_pwm(pwm), .i_pwm_on_dir(pwm_on_dir),
		.o_dir_a(dir_a), .o_dir_b(dir_b), .o_pwm(spd));

	hbridge_mode_fault_chopper uut (.I_CLK_SYS(clk), .I_RESET(reset),
		.I_DIRECTION_IN_A(dir_a), .I_DIRECTION_IN_B(dir_b), .I_SPEED_PWM(spd),
		.I_UNDERVOLTAGE_LOCKOUT(uv), .I_OVERVOLTAGE_SHUTDOWN(ov), .I_THERMAL_SHUTDOWN(therm),
		.I_OVERCURRENT_SHUTDOWN(oc), .I_SENSE_OVERVOLTAGE(sense_ov), .I_SENSE_AT_THRESHOLD(thr),
		.O_BRIDGE_OUT_A_HI(a_hi), .O_BRIDGE_OUT_A_LO(a_lo), .O_BRIDGE_OUT_B_HI(b_hi),
		.O_BRIDGE_OUT_B_LO(b_lo), .O_FAULT_FLAG_O(flag_o), .O_FAULT_FLAG_OE(flag_oe),
		.I_S_AXI_AWVALID(aw_valid), .O_S_AXI_AWREADY(aw_ready), .I_S_AXI_AWADDR(aw_addr),
		.I_S_AXI_WVALID(w_valid), .O_S_AXI_WREADY(w_ready), .I_S_AXI_WDATA(w_data),
		.I_S_AXI_WSTRB(w_strb), .O_S_AXI_BVALID(b_valid), .I_S_AXI_BREADY(b_ready),
		.O_S_AXI_BRESP(b_resp), .I_S_AXI_ARVALID(ar_valid), .O_S_AXI_ARREADY(ar_ready),
		.I_S_AXI_ARADDR(ar_addr), .O_S_AXI_RVALID(r_valid), .I_S_AXI_RREADY(r_ready),
		.O_S_AXI_RDATA(r_data), .O_S_AXI_RRESP(r_resp));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Whole run is about a thousand cycles; this only cuts a hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end

	// Upper and lower of one leg must never conduct together
	always @(posedge clk) begin
		if (!reset && ((a_hi && a_lo) || (b_hi && b_lo))) begin
			n_errors++;
			$display("MISMATCH shoot_through expected 0 seen %b", legs);
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Reference model of the legs: {A_HI, A_LO, B_HI, B_LO}
	function automatic logic [3:0] exp_legs(input int a, input int b, input int p, input int f);
		if (f != 0 || (a == 0 && b == 0)) return 4'h0;
		if ((a == 1 && b == 1) || p == 0) return 4'h5;
		if (a == 0) return 4'h6;
		return 4'h9;
	endfunction

	task automatic drive(input logic [1:0] m, input logic p);
		mode <= m;
		pwm <= p;
		repeat (14) @(posedge clk);
	endtask

	task automatic wait_legs(input logic [3:0] v, input int lim);
		int n;
		n = 0;
		while (legs !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		check("legs_wait", 32'(v), 32'(legs));
	endtask

	task automatic set_fault(input int f, input logic v);
		case (f)
			0: therm <= v;
			1: sense_ov <= v;
			2: oc <= v ? 4'(1 << ($urandom % 4)) : 4'h0;
			3: uv <= v;
			default: ov <= v;
		endcase
	endtask

	task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
		logic done;
		done = 1'b0;
		aw_addr <= addr;
		w_data <= data;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (aw_valid && aw_ready) aw_valid <= 1'b0;
			if (w_valid && w_ready) w_valid <= 1'b0;
			if (b_valid && b_ready) begin
				resp = b_resp;
				b_ready <= 1'b0;
				done = 1'b1;
			end
		end
		@(posedge clk);
	endtask

	task automatic axi_read(input logic [7:0] addr);
		logic done;
		done = 1'b0;
		ar_addr <= addr;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (ar_valid && ar_ready) ar_valid <= 1'b0;
			if (r_valid && r_ready) begin
				rd = r_data;
				resp = r_resp;
				r_ready <= 1'b0;
				done = 1'b1;
			end
		end
		@(posedge clk);
	endtask

	initial begin
		reset = 1'b1;
		mode = 2'h0;
		pwm = 1'b1;
		pwm_on_dir = 1'b0;
		{uv, ov, therm, sense_ov, thr, oc} = '0;
		{aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
		aw_addr = 8'h00;
		ar_addr = 8'h00;
		w_data = 32'h0;
		w_strb = 4'hF;
		{n_errors, cmp_count, cycles} = '0;
		k = $urandom(18);
		repeat (5) @(posedge clk);
		check("legs_reset", 32'h0, 32'(legs));
		check("flag_reset", 32'h0, 32'(flag_oe));
		reset <= 1'b0;
		drive(2'h0, 1'b1);
		check("legs_stop", 32'h0, 32'(legs));
		check("flag_normal", 32'h2, 32'({flag_oe, flag_o}));
		axi_read(`REG_CTRL_ADDR);
		check("ctrl_reset", `CTRL_RESET, rd);
		axi_read(`REG_OSC_ADDR);
		check("osc_reset", `OSC_RESET, rd);
		k = $urandom;
		axi_write(`REG_OSC_ADDR, 32'(k));
		axi_read(`REG_OSC_ADDR);
		check("osc_rw", 32'(k) & `OSC_MASK, rd);
		axi_read(8'h0C);
		check("unmapped_resp", 32'(`RESP_SLVERR), 32'(resp));
		axi_write(`REG_STATUS_ADDR, 32'hFFFF_FFFF);
		check("status_wr_resp", 32'(`RESP_OKAY), 32'(resp));
		axi_write(`REG_OSC_ADDR, 32'h0000_0004);
		// Full decode table, then random revisits in arbitrary order
		for (i = 0; i < 16; i++) begin
			k = (i < 8) ? i : int'($urandom % 8);
			drive(2'(k >> 1), k[0]);
			check("legs_decode", 32'(exp_legs(k >> 2, (k >> 1) & 1, k & 1, 0)), 32'(legs));
		end
		drive(2'h1, 1'b1);
		mode <= 2'h2;
		for (i = 0; i < 20 && a_lo === 1'b1; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		check("dead_time", 32'h0, 32'(a_hi));
		wait_legs(4'h9, 12);
		pwm_on_dir <= 1'b1;
		drive(2'h1, 1'b0);
		check("dir_pwm_low", 32'h5, 32'(legs));
		drive(2'h1, 1'b1);
		check("dir_pwm_high", 32'h6, 32'(legs));
		pwm_on_dir <= 1'b0;
		for (k = 0; k < 5; k++) begin
			drive(2'h1, 1'b1);
			set_fault(k, 1'b1);
			repeat (40) @(posedge clk);
			check("legs_fault", 32'h0, 32'(legs));
			check("flag_fault", 32'h0, 32'(flag_oe));
			set_fault(k, 1'b0);
			drive(2'h2, 1'b1);
			check("legs_after", 32'(exp_legs(1, 0, 1, int'(k < 3))), 32'(legs));
			drive(2'h0, 1'b1);
			check("flag_cleared", 32'h1, 32'(flag_oe));
		end
		drive(2'h1, 1'b1);
		oc <= 4'h2;
		repeat (24) @(posedge clk);
		oc <= 4'h0;
		drive(2'h1, 1'b1);
		check("oc_short", 32'h1, 32'(flag_oe));
		axi_write(`REG_CTRL_ADDR, 32'h0000_0003);
		for (i = 0; i < 2; i++) begin
			oc <= 4'h8;
			repeat (i ? 64 : 48) @(posedge clk);
			oc <= 4'h0;
			repeat (10) @(posedge clk);
			check("oc_mid", 32'(i == 0), 32'(flag_oe));
		end
		drive(2'h0, 1'b1);
		axi_write(`REG_CTRL_ADDR, 32'h0000_0001);
		drive(2'h1, 1'b1);
		thr <= 1'b1;
		repeat (2) @(posedge clk);
		thr <= 1'b0;
		wait_legs(4'h5, 20);
		repeat (6) @(posedge clk);
		check("disch_hold", 32'h5, 32'(legs));
		wait_legs(4'h6, 40);
		thr <= 1'b1;
		wait_legs(4'h5, 20);
		repeat (60) @(posedge clk);
		check("charge_hold", 32'h6, 32'(legs));
		axi_read(`REG_STATUS_ADDR);
		check("chop_state", 32'h3, (rd >> `ST_CHOP_LSB) & 32'h3);
		thr <= 1'b0;
		drive(2'h0, 1'b1);
		final_report();
	end
endmodule

`default_nettype wire
